// ==== hw/ocsw_oscillator_switch.sv ====
// Purpose: clock source control, unlock keys, switch sequencer, doze and postscale control
// Assumes: fuses are static after reset; source clocks and status pins are asynchronous
// Notes:   APB4 slave with zero wait states; all state sits in one registered struct
//
// Functional notes
// - with monitor enabled, selection lock blocks source changes; otherwise never locked
// - multiplier lock follows the synchronised lock pin while a multiplied source is current or being switched to, else 0
// - clock fail flag set by monitor failure, otherwise reads 0
// - drive bit picks high power, else fuse decides; no effect on digital input
// - secondary oscillator runs while its enable bit is 1 or while it is, or is becoming, the current source
// - switch request starts switch to next source; reads 0 when done
// - recover-on-interrupt clears ratio enable on any interrupt
// - ratio code doubles per step 1:1 to 1:128 while enabled, else 1:1
// - fast RC postscale divides 1..64 for codes 0..6, 256 for code 7
// - same postscale divisors apply to low-power fast RC source
// - six-bit read/write trim value for fast RC
// - switching needs switch fuse 0; otherwise request held 0
// - without switching, next source ignored, current source from initial fuse
// - primary submode fixed by fuse, unchanged by runtime switching
// - request with equal current and next source is aborted and cleared
// - valid switch start clears multiplier lock and clock fail flags
// - power new source, wait crystal timer or multiplier lock
// - count ten new-clock cycles before changeover
// - changeover clears request and copies next into current source
// - old source stops except low-power RC in use or enabled secondary
// - high byte keys 78h,9Ah then write; low byte 46h,57h then write
// - eight documented source codes for current and next source
// - monitor needs both switch fuses 0; switching needs upper bit 0
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
module ocsw_oscillator_switch (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // register bus
  input  wire ocsw_pkg::ocsw_apb_req_t apbReq,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // configuration fuses
  input  wire ocsw_pkg::ocsw_fuse_t  fuses,
  // asynchronous source status
  input  wire logic [7:0]            srcClk,
  input  wire logic                  pllLock,
  input  wire logic                  xtalReady,
  input  wire logic                  failDetect,
  // same-clock system events
  input  wire logic                  intReq,
  input  wire logic                  wdtUsesLprc,
  input  wire logic                  rtcUsesLprc,
  // clock tree control
  output logic [7:0]                 srcRun,
  output logic [2:0]                 curSource,
  output logic                       secOscHighPower,
  output logic [2:0]                 cpuRatioCode,
  output logic [3:0]                 postscaleLog2,
  output logic [5:0]                 trimValue
);

  ocsw_pkg::ocsw_state_t q;
  ocsw_pkg::ocsw_state_t d;

  logic [ocsw_pkg::SYNC_W-1:0] filtD;
  logic [ocsw_pkg::SYNC_W-1:0] asyncIn;
  logic                        switchEn;
  logic                        monitorEn;
  logic                        selLocked;
  logic                        setup;
  logic                        access;
  logic                        mapped;
  logic                        wrCtl;
  logic                        wrAny;
  logic [7:0]                  wHi;
  logic [7:0]                  wLo;
  logic                        pllTarget;
  logic                        needXtal;
  logic                        srcReady;
  logic                        newEdge;
  logic                        lprcInUse;
  logic                        failSet;
  logic                        busy;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  assign asyncIn = {failDetect, xtalReady, pllLock, srcClk};

  // a change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < ocsw_pkg::SYNC_W; gi++) begin : g_filt
      assign filtD[gi] = (q.sync2[gi] == q.sync3[gi]) ? q.sync2[gi] : q.filt[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign switchEn  = ~fuses.switchMonitorFuses[1];
  assign monitorEn = (fuses.switchMonitorFuses == 2'h0);
  assign selLocked = monitorEn & q.selLock;
  assign setup     = apbReq.psel & ~apbReq.penable;
  assign access    = apbReq.psel & apbReq.penable;
  assign mapped    = (apbReq.paddr == ocsw_pkg::ADDR_SRC_CTRL) |
                     (apbReq.paddr == ocsw_pkg::ADDR_DIV_CTRL) |
                     (apbReq.paddr == ocsw_pkg::ADDR_TRIM);
  assign wrAny     = access & apbReq.pwrite & mapped;
  assign wrCtl     = wrAny & (apbReq.paddr == ocsw_pkg::ADDR_SRC_CTRL);
  assign wHi       = apbReq.pwdata[15:8];
  assign wLo       = apbReq.pwdata[7:0];
  assign busy      = (q.fsm != ocsw_pkg::ST_IDLE);
  assign pllTarget = (q.nextSrc == ocsw_pkg::SRC_PRI_PLL) |
                     (q.nextSrc == ocsw_pkg::SRC_FRC_PLL);
  // crystal timer only matters for crystal primary submodes
  assign needXtal  = ((q.nextSrc == ocsw_pkg::SRC_PRI) | (q.nextSrc == ocsw_pkg::SRC_PRI_PLL)) &
                     (fuses.primaryModeFuse != ocsw_pkg::PRI_MODE_EC);
  assign srcReady  = (~needXtal | q.filt[ocsw_pkg::SYNC_XTAL]) &
                     (~pllTarget | q.pllLock);
  assign newEdge   = filtD[q.nextSrc] & ~q.filt[q.nextSrc];
  assign lprcInUse = wdtUsesLprc | rtcUsesLprc | monitorEn;
  assign failSet   = monitorEn & q.filt[ocsw_pkg::SYNC_FAIL];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.sync1 = asyncIn;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.filt  = filtD;

    // straps are taken on the first edge after reset release
    if (!q.fuseLoaded) begin
      d.fuseLoaded = 1'b1;
      d.curSrc     = fuses.initialSourceFuse;
      d.nextSrc    = fuses.initialSourceFuse;
      d.srcRun     = 8'h01 << fuses.initialSourceFuse;
    end

    // read data is captured in setup so the access phase needs no wait
    if (setup) begin
      case (apbReq.paddr)
        ocsw_pkg::ADDR_SRC_CTRL: d.rdata = {16'h0000, 1'b0, q.curSrc, 1'b0, q.nextSrc,
                                            q.selLock, 1'b0, q.pllLock, 1'b0, q.clkFail,
                                            q.secDrive, q.secEnable, q.switchReq};
        ocsw_pkg::ADDR_DIV_CTRL: d.rdata = {16'h0000, q.recoverOnInt, q.ratio,
                                            q.ratioEnable, q.postscale, 8'h00};
        ocsw_pkg::ADDR_TRIM:     d.rdata = {26'h0000000, q.trim};
        default:                 d.rdata = 32'h00000000;
      endcase
    end

    // high byte: two keys, then one write of the next source
    if (wrCtl && apbReq.pstrb[1]) begin
      if (q.hiKey == ocsw_pkg::KEY_OPEN) begin
        if (switchEn && !selLocked && !busy && q.fuseLoaded) begin
          d.nextSrc = wHi[2:0];
        end
        d.hiKey = ocsw_pkg::KEY_IDLE;
      end else if (q.hiKey == ocsw_pkg::KEY_HALF && wHi == ocsw_pkg::HI_KEY2) begin
        d.hiKey = ocsw_pkg::KEY_OPEN;
      end else if (wHi == ocsw_pkg::HI_KEY1) begin
        d.hiKey = ocsw_pkg::KEY_HALF;
      end else begin
        d.hiKey = ocsw_pkg::KEY_IDLE;
      end
    end else if (wrAny) begin
      d.hiKey = ocsw_pkg::KEY_IDLE;
    end

    // low byte: two keys, then one write of the control bits
    if (wrCtl && apbReq.pstrb[0]) begin
      if (q.loKey == ocsw_pkg::KEY_OPEN) begin
        if (monitorEn && wLo[7]) begin
          d.selLock = 1'b1;
        end
        if (!wLo[3]) begin
          d.clkFail = 1'b0;
        end
        d.secDrive  = wLo[2];
        d.secEnable = wLo[1];
        if (wLo[0] && switchEn && !selLocked && q.fuseLoaded) begin
          d.switchReq = 1'b1;
        end
        d.loKey = ocsw_pkg::KEY_IDLE;
      end else if (q.loKey == ocsw_pkg::KEY_HALF && wLo == ocsw_pkg::LO_KEY2) begin
        d.loKey = ocsw_pkg::KEY_OPEN;
      end else if (wLo == ocsw_pkg::LO_KEY1) begin
        d.loKey = ocsw_pkg::KEY_HALF;
      end else begin
        d.loKey = ocsw_pkg::KEY_IDLE;
      end
    end else if (wrAny) begin
      d.loKey = ocsw_pkg::KEY_IDLE;
    end

    if (wrAny && apbReq.paddr == ocsw_pkg::ADDR_DIV_CTRL && apbReq.pstrb[1]) begin
      d.recoverOnInt = apbReq.pwdata[15];
      d.ratio        = apbReq.pwdata[14:12];
      d.ratioEnable  = apbReq.pwdata[11];
      d.postscale    = apbReq.pwdata[10:8];
    end
    if (wrAny && apbReq.paddr == ocsw_pkg::ADDR_TRIM && apbReq.pstrb[0]) begin
      d.trim = wLo[5:0];
    end

    // an interrupt overrides a same-cycle software write of the enable
    if (q.recoverOnInt && intReq) begin
      d.ratioEnable = 1'b0;
    end

    // lock tracks the synchronised pin only while a multiplied source is in play
    d.pllLock = q.filt[ocsw_pkg::SYNC_PLL] &
                ((q.curSrc == ocsw_pkg::SRC_PRI_PLL) | (q.curSrc == ocsw_pkg::SRC_FRC_PLL) |
                 (busy & pllTarget));

    // switch sequencer
    case (q.fsm)
      ocsw_pkg::ST_IDLE: begin
        if (q.switchReq && switchEn && q.fuseLoaded) begin
          d.fsm = ocsw_pkg::ST_CHECK;
        end
      end
      ocsw_pkg::ST_CHECK: begin
        if (q.curSrc == q.nextSrc) begin
          d.switchReq = 1'b0;
          d.fsm       = ocsw_pkg::ST_IDLE;
        end else begin
          d.pllLock        = 1'b0;
          d.clkFail        = 1'b0;
          d.srcRun[q.nextSrc] = 1'b1;
          d.edgeCnt        = 4'h0;
          d.fsm            = ocsw_pkg::ST_WAIT;
        end
      end
      ocsw_pkg::ST_WAIT: begin
        if (srcReady) begin
          d.fsm = ocsw_pkg::ST_COUNT;
        end
      end
      ocsw_pkg::ST_COUNT: begin
        if (newEdge) begin
          d.edgeCnt = q.edgeCnt + 4'h1;
          if (q.edgeCnt == ocsw_pkg::NEW_EDGES - 4'h1) begin
            d.fsm = ocsw_pkg::ST_DONE;
          end
        end
      end
      ocsw_pkg::ST_DONE: begin
        d.curSrc    = q.nextSrc;
        d.switchReq = 1'b0;
        if (!(q.curSrc == ocsw_pkg::SRC_LOW_POWER_INTERNAL_RC && lprcInUse)) begin
          d.srcRun[q.curSrc] = 1'b0;
        end
        d.fsm = ocsw_pkg::ST_IDLE;
      end
      default: begin
        d.fsm = ocsw_pkg::ST_IDLE;
      end
    endcase

    // the secondary runs on its enable, or while it is, or is becoming, the system clock
    d.srcRun[ocsw_pkg::SRC_SECONDARY_OSCILLATOR] = d.secEnable | (d.curSrc == ocsw_pkg::SRC_SECONDARY_OSCILLATOR) |
                                   ((d.fsm != ocsw_pkg::ST_IDLE) &
                                    (d.nextSrc == ocsw_pkg::SRC_SECONDARY_OSCILLATOR));

    // a failure seen in the clearing cycle still sets the flag
    if (failSet) begin
      d.clkFail = 1'b1;
    end
    if (!switchEn) begin
      d.switchReq = 1'b0;
    end

    d.secHighPower = ~fuses.secOscDigitalIn & (d.secDrive | fuses.secOscSourceFuse);
    d.effRatio     = d.ratioEnable ? d.ratio : 3'h0;
    if (d.curSrc == ocsw_pkg::SRC_FRC_DIV || d.curSrc == ocsw_pkg::SRC_FRC_PLL ||
        d.curSrc == ocsw_pkg::SRC_LPFRC_DIV) begin
      d.postLog2 = (d.postscale == 3'h7) ? ocsw_pkg::POST_MAX
                                          : {1'b0, d.postscale};
    end else begin
      d.postLog2 = 4'h0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= ocsw_pkg::STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata          = q.rdata;
  assign pready          = 1'b1;
  assign pslverr         = access & ~mapped;
  assign srcRun          = q.srcRun;
  assign curSource       = q.curSrc;
  assign secOscHighPower = q.secHighPower;
  assign cpuRatioCode    = q.effRatio;
  assign postscaleLog2   = q.postLog2;
  assign trimValue       = q.trim;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  request_held_a: assert property (!switchEn |-> ##1 !q.switchReq)
    else $error("switch request set with switching disabled");

  redundant_abort_a: assert property (
    (q.fsm == ocsw_pkg::ST_CHECK && q.curSrc == q.nextSrc)
    |=> (q.fsm == ocsw_pkg::ST_IDLE && !q.switchReq))
    else $error("redundant switch not aborted");

  start_clears_a: assert property (
    (q.fsm == ocsw_pkg::ST_CHECK && q.curSrc != q.nextSrc && !failSet)
    |=> (!q.pllLock && !q.clkFail && q.fsm == ocsw_pkg::ST_WAIT))
    else $error("switch start did not clear lock and fail flags");

  ten_edges_a: assert property (
    $rose(q.fsm == ocsw_pkg::ST_DONE) |-> q.edgeCnt == 4'hA)
    else $error("changeover before ten new-clock cycles");

  copy_done_a: assert property (
    (q.fsm == ocsw_pkg::ST_DONE)
    |=> (q.curSrc == $past(q.nextSrc) && !q.switchReq && q.fsm == ocsw_pkg::ST_IDLE))
    else $error("changeover did not copy source or clear request");

  old_stop_a: assert property (
    (q.fsm == ocsw_pkg::ST_DONE && q.curSrc != ocsw_pkg::SRC_LOW_POWER_INTERNAL_RC &&
     q.curSrc != ocsw_pkg::SRC_SECONDARY_OSCILLATOR)
    |=> !q.srcRun[$past(q.curSrc)])
    else $error("old source still running after changeover");

  doze_recover_a: assert property (
    (q.recoverOnInt && intReq) |=> (!q.ratioEnable && q.effRatio == 3'h0))
    else $error("interrupt did not restore 1:1 ratio");

  ratio_map_a: assert property (
    q.effRatio == (q.ratioEnable ? q.ratio : 3'h0))
    else $error("cpu ratio code wrong");

  post_map_a: assert property (
    (q.curSrc == ocsw_pkg::SRC_FRC_DIV && q.postscale == 3'h7 && $stable(q.curSrc) &&
     $stable(q.postscale)) |-> q.postLog2 == 4'h8)
    else $error("postscale code seven must divide by 256");

  key_guard_a: assert property (
    (wrCtl && apbReq.pstrb[1] && q.hiKey != ocsw_pkg::KEY_OPEN && !busy && q.fuseLoaded)
    |=> $stable(q.nextSrc))
    else $error("next source written without unlock keys");

  fail_set_a: assert property (failSet |=> q.clkFail)
    else $error("clock failure not flagged");

  sec_run_a: assert property (q.secEnable |-> q.srcRun[ocsw_pkg::SRC_SECONDARY_OSCILLATOR])
    else $error("secondary oscillator stopped while enabled");

endmodule // ocsw_oscillator_switch

// ==== pkg/ocsw_pkg.sv ====
// Purpose: shared constants and types of the oscillator switch and divider block
// Assumes: 32-bit APB4 register port, one 40 MHz clock
// Notes:   source codes, register addresses and reset values live here only
package ocsw_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_SRC_CTRL = 12'h000;
  localparam logic [11:0] ADDR_DIV_CTRL = 12'h004;
  localparam logic [11:0] ADDR_TRIM     = 12'h008;

  // ----------------------------------------------------------------
  // source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_FRC_DIV   = 3'h7;
  localparam logic [2:0] SRC_LPFRC_DIV = 3'h6;
  localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC      = 3'h5;
  localparam logic [2:0] SRC_SECONDARY_OSCILLATOR      = 3'h4;
  localparam logic [2:0] SRC_PRI_PLL   = 3'h3;
  localparam logic [2:0] SRC_PRI       = 3'h2;
  localparam logic [2:0] SRC_FRC_PLL   = 3'h1;
  localparam logic [2:0] SRC_FRC       = 3'h0;
  localparam logic [1:0] PRI_MODE_EC   = 2'h0;

  // ----------------------------------------------------------------
  // unlock keys, reset values, counts
  // ----------------------------------------------------------------
  localparam logic [7:0] HI_KEY1    = 8'h78;
  localparam logic [7:0] HI_KEY2    = 8'h9A;
  localparam logic [7:0] LO_KEY1    = 8'h46;
  localparam logic [7:0] LO_KEY2    = 8'h57;
  localparam logic [1:0] KEY_IDLE   = 2'h0;
  localparam logic [1:0] KEY_HALF   = 2'h1;
  localparam logic [1:0] KEY_OPEN   = 2'h2;
  localparam logic [2:0] DOZE_RST   = 3'h3;
  localparam logic [2:0] FAST_RC_POSTSCALE_RST  = 3'h1;
  localparam logic [3:0] NEW_EDGES  = 4'hA;
  localparam logic [3:0] POST_MAX   = 4'h8;
  localparam int         SYNC_W     = 11;
  localparam int         SYNC_PLL   = 8;
  localparam int         SYNC_XTAL  = 9;
  localparam int         SYNC_FAIL  = 10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_CHECK = 5'h02,
    ST_WAIT  = 5'h04,
    ST_COUNT = 5'h08,
    ST_DONE  = 5'h10
  } ocsw_fsm_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } ocsw_apb_req_t;

  typedef struct packed {
    logic [1:0] switchMonitorFuses;
    logic [2:0] initialSourceFuse;
    logic [1:0] primaryModeFuse;
    logic       secOscSourceFuse;
    logic       secOscDigitalIn;
  } ocsw_fuse_t;

  typedef struct packed {
    logic              fuseLoaded;
    logic [2:0]        curSrc;
    logic [2:0]        nextSrc;
    logic              selLock;
    logic              pllLock;
    logic              clkFail;
    logic              secDrive;
    logic              secEnable;
    logic              switchReq;
    logic [1:0]        hiKey;
    logic [1:0]        loKey;
    logic              recoverOnInt;
    logic [2:0]        ratio;
    logic              ratioEnable;
    logic [2:0]        postscale;
    logic [5:0]        trim;
    ocsw_fsm_t         fsm;
    logic [3:0]        edgeCnt;
    logic [7:0]        srcRun;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] filt;
    logic [2:0]        effRatio;
    logic [3:0]        postLog2;
    logic              secHighPower;
    logic [31:0]       rdata;
  } ocsw_state_t;

  localparam ocsw_state_t STATE_RST = '{
    fsm:     ST_IDLE,
    ratio:   DOZE_RST,
    postscale: FAST_RC_POSTSCALE_RST,
    default: '0
  };

endpackage

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the oscillator switch and divider block
// Assumes: switching and monitor fuses programmed 0, start-up on fast RC with postscaler
// Notes:   crystal pin tied ready; every source clock comes from one slow toggle
`timescale 1ns/1ps
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin errTotal++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  logic                    ref_clk = 1'b0;
  logic                    sys_rst = 1'b1;
  ocsw_pkg::ocsw_apb_req_t req     = '0;
  ocsw_pkg::ocsw_fuse_t    fuses   = '{2'h0, 3'h7, 2'h3, 1'b0, 1'b0};
  logic [7:0]              srcClk  = '0;
  logic [2:0]              divCnt  = '0;
  logic                    intReq  = 1'b0;
  logic                    failIn  = 1'b0;
  logic                    lockIn  = 1'b1;
  logic [31:0]             prdata, rdData;
  logic                    pready, pslverr, rdErr, secHp;
  logic [7:0]              srcRun;
  logic [2:0]              curSrc, ratio;
  logic [3:0]              postLog;
  logic [5:0]              trim;
  int                      errTotal = 0;
  int                      nChecks  = 0;

  always #12.5 ref_clk = ~ref_clk;
  // source clocks well below ref_clk so the synchroniser sees every edge
  always @(posedge ref_clk) begin
    divCnt <= divCnt + 3'h1;
    srcClk <= {8{divCnt[2]}};
  end

  ocsw_oscillator_switch DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .apbReq(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fuses(fuses), .srcClk(srcClk),
    .pllLock(lockIn), .xtalReady(1'b1), .failDetect(failIn), .intReq(intReq),
    .wdtUsesLprc(1'b0), .rtcUsesLprc(1'b0), .srcRun(srcRun), .curSource(curSrc),
    .secOscHighPower(secHp), .cpuRatioCode(ratio), .postscaleLog2(postLog),
    .trimValue(trim));

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, wr, a, d, s};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdData = prdata;
    rdErr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic keyed(input logic [7:0] k1, k2, input logic [31:0] v, input logic [3:0] s);
    apb(1'b1, ocsw_pkg::ADDR_SRC_CTRL, {16'h0, k1, k1}, s);
    apb(1'b1, ocsw_pkg::ADDR_SRC_CTRL, {16'h0, k2, k2}, s);
    apb(1'b1, ocsw_pkg::ADDR_SRC_CTRL, v, s);
  endtask

  task automatic pulseInt();
    @(posedge ref_clk) intReq <= 1'b1;
    @(posedge ref_clk) intReq <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic stopTest();
    if (errTotal == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge ref_clk);
    errTotal++;
    stopTest();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, ocsw_pkg::ADDR_SRC_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_7700)
    apb(1'b0, ocsw_pkg::ADDR_DIV_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_3100)
    apb(1'b1, ocsw_pkg::ADDR_TRIM, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, ocsw_pkg::ADDR_TRIM, '0, 4'h0);
    `CHK(rdData, 32'h0000_003F)
    `CHK(trim, 6'h3F)
    apb(1'b0, 12'h00C, '0, 4'h0);
    `CHK({rdErr, rdData}, 33'h1_0000_0000)
    // doze without recovery, largest postscale code on the 8 MHz source
    apb(1'b1, ocsw_pkg::ADDR_DIV_CTRL, 32'h0000_7F00, 4'h2);
    pulseInt();
    `CHK({ratio, postLog}, 7'h78)
    apb(1'b1, ocsw_pkg::ADDR_DIV_CTRL, 32'h0000_BA00, 4'h2);
    repeat (3) @(posedge ref_clk);
    `CHK({ratio, postLog}, 7'h32)
    pulseInt();
    `CHK(ratio, 3'h0)
    apb(1'b0, ocsw_pkg::ADDR_DIV_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_B200)
    // a high-byte write without keys must be dropped
    apb(1'b1, ocsw_pkg::ADDR_SRC_CTRL, 32'h0, 4'h2);
    apb(1'b0, ocsw_pkg::ADDR_SRC_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_7700)
    keyed(8'h78, 8'h9A, 32'h0, 4'h2);
    keyed(8'h46, 8'h57, 32'h1, 4'h1);
    for (int i = 0; i < 300 && curSrc !== 3'h0; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    `CHK(curSrc, 3'h0)
    `CHK({srcRun[7], srcRun[0], postLog}, 6'h10)
    apb(1'b0, ocsw_pkg::ADDR_SRC_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_0000)
    // request to the source already running, drive bit raised alongside
    keyed(8'h46, 8'h57, 32'h5, 4'h1);
    repeat (3) @(posedge ref_clk);
    apb(1'b0, ocsw_pkg::ADDR_SRC_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_0004)
    `CHK({curSrc, secHp}, 4'h1)
    // monitor failure pulse; lock pin drops ahead of the multiplied switch
    failIn <= 1'b1;
    lockIn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    failIn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    apb(1'b0, ocsw_pkg::ADDR_SRC_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_000C)
    // fast RC to fast RC with multiplier; fail bit written 1 so only the start clears it
    keyed(8'h78, 8'h9A, 32'h0000_0100, 4'h2);
    keyed(8'h46, 8'h57, 32'h0000_000D, 4'h1);
    repeat (60) @(posedge ref_clk);
    apb(1'b0, ocsw_pkg::ADDR_SRC_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_0105)
    `CHK(curSrc, 3'h0)
    lockIn <= 1'b1;
    for (int i = 0; i < 300 && curSrc !== 3'h1; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    `CHK(curSrc, 3'h1)
    apb(1'b0, ocsw_pkg::ADDR_SRC_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_1124)
    `CHK({srcRun[1:0], postLog}, 6'h22)
    // on to the low-power fast RC, then lock the selection
    keyed(8'h78, 8'h9A, 32'h0000_0600, 4'h2);
    keyed(8'h46, 8'h57, 32'h0000_0005, 4'h1);
    for (int i = 0; i < 300 && curSrc !== 3'h6; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    `CHK({curSrc, postLog}, 7'h62)
    keyed(8'h46, 8'h57, 32'h0000_0084, 4'h1);
    keyed(8'h78, 8'h9A, 32'h0000_0000, 4'h2);
    apb(1'b0, ocsw_pkg::ADDR_SRC_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_6684)
    // second reset with switching fuse unprogrammed
    fuses   <= '{2'h3, 3'h7, 2'h3, 1'b0, 1'b0};
    sys_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    keyed(8'h78, 8'h9A, 32'h0000_0000, 4'h2);
    keyed(8'h46, 8'h57, 32'h0000_0001, 4'h1);
    repeat (3) @(posedge ref_clk);
    apb(1'b0, ocsw_pkg::ADDR_SRC_CTRL, '0, 4'h0);
    `CHK(rdData, 32'h0000_7700)
    `CHK(curSrc, 3'h7)
    stopTest();
  end
endmodule // tb_top
